// ---- verilog/dpwm_top.sv ----
`timescale 1ns/1ps
module dpwm_top (
  input  wire logic        CLK_SYS_I,  // 10 MHz clock
  input  wire logic        RST_I,      // Sync reset, high
  input  wire logic        OPENING_I,  // Door opening state
  input  wire logic        CLOSING_I,  // Door closing state
  input  wire logic        ENTER_I,    // Transition into open/close
  input  wire logic [31:0] ADDR_I,     // Register address
  input  wire logic [31:0] WDATA_I,    // Write data
  input  wire logic        WR_I,       // Write strobe
  input  wire logic        RD_I,       // Read strobe
  output logic      [31:0] RDATA_O,    // Read data, next cycle
  output logic             OPEN_PWM_O, // Opening PWM output
  output logic             CLOSE_PWM_O,// Closing PWM output
  output logic             IRQ_O,      // Host interrupt pulse
  output logic      [7:0]  IRQ_TAG_O   // Interrupt tag
);
  localparam int W = dpwm_pkg::DATA_W;
  localparam int D = dpwm_pkg::FIFO_DEPTH;
  localparam int PW = dpwm_pkg::PTR_W;

  dpwm_pkg::dpwm_door_t door;
  logic [W-1:0] period, next_period;
  logic [W-1:0] duty, next_duty;
  logic [W-1:0] match2, next_match2;
  logic [W-1:0] count, next_count;
  logic [W-1:0] gen_one, next_gen_one;
  logic [7:0]   flags, next_flags;
  logic         pwm_state_bit, next_pwm_state_bit;
  logic         trig_q, next_trig_q;
  logic         underflow, next_underflow;
  logic [W-1:0] fifo_mem [D];
  logic [dpwm_pkg::PTR_W-1:0] wr_ptr, rd_ptr, level;
  logic [PW-1:0] next_wr_ptr, next_rd_ptr, next_level;
  logic [W-1:0] fifo_head;
  logic         duty_wr;
  logic [W-1:0] rdata, next_rdata;
  logic         irq, next_irq;
  dpwm_pkg::dpwm_seq_t seq, next_seq;
  logic         enable, zero_ev, match_ev, trigger, trig_rise;
  logic         push, pop;

  function automatic logic addr_is(input logic [31:0] a,
                                   input logic [31:0] b);
    return a == b;
  endfunction

  assign door.opening = OPENING_I & ~CLOSING_I;
  assign door.closing = CLOSING_I & ~OPENING_I;
  assign enable   = door.opening | door.closing;
  assign zero_ev  = enable && (count == '0);
  assign match_ev = enable && (count == duty);
  assign trigger  = zero_ev & flags[dpwm_pkg::ANNOUNCE_BIT];
  assign trig_rise = trigger & ~trig_q;
  assign push = WR_I && addr_is(ADDR_I, dpwm_pkg::ADDR_FIFO)
                && (level != PW'(D));
  assign pop  = (seq == dpwm_pkg::SEQ_POP_C || seq == dpwm_pkg::SEQ_POP_G)
                && (level != '0);
  assign fifo_head = fifo_mem[rd_ptr[1:0]];
  assign duty_wr   = WR_I && addr_is(ADDR_I, dpwm_pkg::ADDR_DUTY);

  always_comb begin
    next_period = period;
    next_duty   = duty;
    next_match2 = match2;
    next_flags  = flags;
    next_count  = count;
    next_gen_one = gen_one;
    next_seq    = seq;
    next_irq    = 1'b0;
    next_underflow = underflow;
    next_trig_q = trigger;
    next_pwm_state_bit = pwm_state_bit;
    if (WR_I) begin
      if (addr_is(ADDR_I, dpwm_pkg::ADDR_PERIOD))
        next_period = WDATA_I;
      if (addr_is(ADDR_I, dpwm_pkg::ADDR_DUTY))
        next_duty = WDATA_I;
      if (addr_is(ADDR_I, dpwm_pkg::ADDR_MATCH2))
        next_match2 = WDATA_I;
      if (addr_is(ADDR_I, dpwm_pkg::ADDR_FLAG))
        next_flags = WDATA_I[7:0];
      if (addr_is(ADDR_I, dpwm_pkg::ADDR_STAT))
        next_underflow = underflow & ~WDATA_I[0];
    end
    // Counter: reset on entry, else count down and reload at zero
    if (ENTER_I)
      next_count = period;
    else if (enable) begin
      if (count == '0)
        next_count = period;
      else
        next_count = count - 1'b1;
    end
    // Zero checked first so it wins a tie with match
    if (zero_ev)
      next_pwm_state_bit = 1'b0;
    else if (match_ev)
      next_pwm_state_bit = 1'b1;
    unique case (seq)
      dpwm_pkg::SEQ_IDLE: begin
        if (trig_rise)
          next_seq = dpwm_pkg::SEQ_POP_C;
      end
      dpwm_pkg::SEQ_POP_C: begin
        if (pop)
          next_count = fifo_head;
        else
          next_underflow = 1'b1;
        next_seq = dpwm_pkg::SEQ_POP_G;
      end
      dpwm_pkg::SEQ_POP_G: begin
        // Pops land only in count or general one, never in a match
        if (pop)
          next_gen_one = fifo_head;
        else
          next_underflow = 1'b1;
        next_seq = dpwm_pkg::SEQ_MOV_M;
      end
      dpwm_pkg::SEQ_MOV_M: begin
        next_duty = gen_one;
        next_seq  = dpwm_pkg::SEQ_RAISE_HOST_INTERRUPT;
      end
      dpwm_pkg::SEQ_RAISE_HOST_INTERRUPT: begin
        next_irq = 1'b1;
        next_seq = dpwm_pkg::SEQ_IDLE;
      end
      default: next_seq = dpwm_pkg::SEQ_IDLE;
    endcase
  end

  always_comb begin
    next_rdata = '0;
    if (RD_I) begin
      if (addr_is(ADDR_I, dpwm_pkg::ADDR_PERIOD))
        next_rdata = period;
      else if (addr_is(ADDR_I, dpwm_pkg::ADDR_DUTY))
        next_rdata = duty;
      else if (addr_is(ADDR_I, dpwm_pkg::ADDR_COUNT))
        next_rdata = count;
      else if (addr_is(ADDR_I, dpwm_pkg::ADDR_FLAG))
        next_rdata = {24'h000000, flags};
      else if (addr_is(ADDR_I, dpwm_pkg::ADDR_STAT))
        next_rdata = {25'h0000000, level, seq != dpwm_pkg::SEQ_IDLE,
                      pwm_state_bit, 1'b0, underflow};
      else if (addr_is(ADDR_I, dpwm_pkg::ADDR_MATCH2))
        next_rdata = match2;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      period <= dpwm_pkg::PERIOD_RST;
      duty   <= dpwm_pkg::DUTY_RST;
      match2 <= '0;
      flags  <= '0;
      count  <= '0;
      gen_one <= '0;
      seq    <= dpwm_pkg::SEQ_IDLE;
      irq    <= 1'b0;
      underflow <= 1'b0;
      trig_q <= 1'b0;
      pwm_state_bit <= 1'b0;
      rdata  <= '0;
    end else begin
      period <= next_period;
      duty   <= next_duty;
      match2 <= next_match2;
      flags  <= next_flags;
      count  <= next_count;
      gen_one <= next_gen_one;
      seq    <= next_seq;
      irq    <= next_irq;
      underflow <= next_underflow;
      trig_q <= next_trig_q;
      pwm_state_bit <= next_pwm_state_bit;
      rdata  <= next_rdata;
    end
  end

  // Overflowing pushes are dropped; the host is told by the level field
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push)
      next_wr_ptr = wr_ptr + 1'b1;
    if (pop)
      next_rd_ptr = rd_ptr + 1'b1;
    next_level = level + PW'(push) - PW'(pop);
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push)
        fifo_mem[wr_ptr[1:0]] <= WDATA_I;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
    end
  end

  assign RDATA_O     = rdata;
  assign OPEN_PWM_O  = pwm_state_bit & door.opening;
  assign CLOSE_PWM_O = pwm_state_bit & door.closing;
  assign IRQ_O       = irq;
  assign IRQ_TAG_O   = dpwm_pkg::DONE_TAG;

  a_zero_clears: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    zero_ev |=> !pwm_state_bit)
    else $error("zero did not clear");
  a_match_sets: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    match_ev && !zero_ev |=> pwm_state_bit)
    else $error("match did not set");
  a_tie_zero_wins: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    zero_ev && match_ev |=> !pwm_state_bit)
    else $error("tie not low");
  a_open_route: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    door.opening |-> OPEN_PWM_O == pwm_state_bit && !CLOSE_PWM_O)
    else $error("opening route");
  a_close_route: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    door.closing |-> CLOSE_PWM_O == pwm_state_bit && !OPEN_PWM_O)
    else $error("closing route");
  a_idle_route: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !door.opening && !door.closing |-> !OPEN_PWM_O && !CLOSE_PWM_O)
    else $error("output active outside both states");
  a_seq_start: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    seq == dpwm_pkg::SEQ_IDLE && trig_rise |=> seq == dpwm_pkg::SEQ_POP_C)
    else $error("sequencer did not start");
  a_irq_after: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    seq == dpwm_pkg::SEQ_IDLE && trig_rise |=> ##4 IRQ_O)
    else $error("no interrupt");
  a_irq_pulse: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    IRQ_O |=> !IRQ_O)
    else $error("interrupt longer than one cycle");
  a_seq_order: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    seq == dpwm_pkg::SEQ_POP_C |=> seq == dpwm_pkg::SEQ_POP_G ##1
      seq == dpwm_pkg::SEQ_MOV_M ##1 seq == dpwm_pkg::SEQ_RAISE_HOST_INTERRUPT)
    else $error("sequencer out of order");
  a_only_at_zero: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    seq == dpwm_pkg::SEQ_IDLE && !zero_ev |=> seq == dpwm_pkg::SEQ_IDLE)
    else $error("update started away from zero");
  a_pop_count: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    seq == dpwm_pkg::SEQ_POP_C && level != '0 |=> count == $past(fifo_head))
    else $error("period word not loaded");
  a_pop_general: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    seq == dpwm_pkg::SEQ_POP_G && level != '0
      |=> gen_one == $past(fifo_head))
    else $error("duty word not popped");
  a_duty_move: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    seq == dpwm_pkg::SEQ_MOV_M |=> duty == $past(gen_one))
    else $error("duty not moved");
  a_duty_guard: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !duty_wr && seq != dpwm_pkg::SEQ_MOV_M |=> $stable(duty))
    else $error("duty changed outside a move");
  a_no_trig: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !flags[dpwm_pkg::ANNOUNCE_BIT] && seq == dpwm_pkg::SEQ_IDLE
      |=> seq == dpwm_pkg::SEQ_IDLE)
    else $error("update without flag");
  a_enter_reset: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    ENTER_I && seq != dpwm_pkg::SEQ_POP_C |=> count == $past(period))
    else $error("entry did not reset");
  a_reload_zero: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    zero_ev && !ENTER_I && seq != dpwm_pkg::SEQ_POP_C
      |=> count == $past(period))
    else $error("no reload at zero");
  a_count_down: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    enable && count != '0 && !ENTER_I && seq != dpwm_pkg::SEQ_POP_C
      |=> count == $past(count) - 32'h00000001)
    else $error("count did not step down");
  a_count_hold: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !enable && !ENTER_I && seq != dpwm_pkg::SEQ_POP_C |=> $stable(count))
    else $error("count moved while disabled");
  a_level_max: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    level <= PW'(D))
    else $error("fifo overfull");
  a_underflow_set: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    seq == dpwm_pkg::SEQ_POP_C && level == '0 |=> underflow)
    else $error("empty pop not flagged");

  c_update: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    trig_rise ##5 IRQ_O);
  c_open_pwm: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    OPEN_PWM_O);
  c_close_pwm: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    CLOSE_PWM_O);
  c_fifo_full: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    level == PW'(D));
  c_underflow: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    seq == dpwm_pkg::SEQ_POP_C && level == '0);
endmodule

// ---- verilog/dpwm_pkg.sv ----
package dpwm_pkg;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 3;
  localparam int FLAG_W = 8;
  localparam int ANNOUNCE_BIT = 2;
  localparam logic [7:0] DONE_TAG = 8'h01;
  localparam logic [31:0] PERIOD_RST = 32'h00000fa0;
  localparam logic [31:0] DUTY_RST = 32'h000007d0;
  localparam logic [31:0] ADDR_PERIOD = 32'h00000000;
  localparam logic [31:0] ADDR_DUTY = 32'h00000004;
  localparam logic [31:0] ADDR_COUNT = 32'h00000008;
  localparam logic [31:0] ADDR_FIFO = 32'h0000000c;
  localparam logic [31:0] ADDR_FLAG = 32'h00000010;
  localparam logic [31:0] ADDR_STAT = 32'h00000014;
  localparam logic [31:0] ADDR_MATCH2 = 32'h00000018;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_POP_C = 3'b001,
    SEQ_POP_G = 3'b010,
    SEQ_MOV_M = 3'b011,
    SEQ_RAISE_HOST_INTERRUPT  = 3'b100
  } dpwm_seq_t;

  typedef struct packed {
    logic opening;
    logic closing;
  } dpwm_door_t;
endpackage

// ---- testbench/dpwm_host.sv ----
`timescale 1ns/1ps
module dpwm_host (
  input  wire logic        clk_i,   // System clock
  input  wire logic        irq_i,   // Completion pulse
  input  wire logic [7:0]  tag_i,   // Interrupt tag
  input  wire logic [31:0] rdata_i, // Read data
  output logic      [31:0] addr_o,  // Address
  output logic      [31:0] wdata_o, // Write data
  output logic             wr_o,    // Write strobe
  output logic             rd_o     // Read strobe
);
  initial begin
    addr_o  = 32'h0;
    wdata_o = 32'h0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask

  task automatic update(input logic [31:0] p, input logic [31:0] d);
    wr(dpwm_pkg::ADDR_PERIOD, p);
    wr(dpwm_pkg::ADDR_FIFO, p);
    wr(dpwm_pkg::ADDR_FIFO, d);
    wr(dpwm_pkg::ADDR_FLAG, 32'h00000004);
  endtask

  // Flag stays set unless a tagged completion is seen
  task automatic finish_upd(input int lim, output bit got);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge clk_i);
      got = (irq_i === 1'b1) && (tag_i === 8'h01);
    end
    if (got) wr(dpwm_pkg::ADDR_FLAG, 32'h00000000);
  endtask
endmodule

// ---- testbench/dpwm_top_tb.sv ----
`timescale 1ns/1ps
module dpwm_top_tb;
  logic        CLK_SYS_I = 1'b0;
  logic        RST_I     = 1'b1;
  logic        OPENING_I = 1'b0;
  logic        CLOSING_I = 1'b0;
  logic        ENTER_I   = 1'b0;
  logic [31:0] ADDR_I, WDATA_I, RDATA_O, v;
  logic        WR_I, RD_I, OPEN_PWM_O, CLOSE_PWM_O, IRQ_O;
  logic [7:0]  IRQ_TAG_O;
  logic [15:0] lfsr       = 16'h0031;
  int          fail_count = 0;
  int          checks     = 0;
  int          p, d;
  bit          got;

  always #50 CLK_SYS_I = ~CLK_SYS_I;

  dpwm_top dpwm_top_inst (.CLK_SYS_I, .RST_I, .OPENING_I, .CLOSING_I,
    .ENTER_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .OPEN_PWM_O,
    .CLOSE_PWM_O, .IRQ_O, .IRQ_TAG_O);
  dpwm_host dpwm_host_inst (.clk_i(CLK_SYS_I), .irq_i(IRQ_O),
    .tag_i(IRQ_TAG_O), .rdata_i(RDATA_O), .addr_o(ADDR_I),
    .wdata_o(WDATA_I), .wr_o(WR_I), .rd_o(RD_I));

  function automatic int rnd(input int lo, input int span);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lo + (lfsr % span);
  endfunction

  // High cycles over two periods of p+1 cycles; a tie with zero stays low
  function automatic int exp_high(input int dd, input int pp);
    return (dd <= pp) ? 2 * dd : 0;
  endfunction

  task automatic results();
    $display("Summary: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rchk(input logic [31:0] a, input string n,
                      input logic [31:0] m, input logic [31:0] e);
    dpwm_host_inst.rd(a, v);
    chk(n, e, v & m);
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(posedge CLK_SYS_I);
    OPENING_I <= m[0];
    CLOSING_I <= m[1];
    ENTER_I   <= 1'b1;
    @(posedge CLK_SYS_I);
    ENTER_I   <= 1'b0;
  endtask

  // One period of settling first, so a stale state bit is not counted
  task automatic measure(input logic [1:0] m);
    int ho, hc;
    ho = 0;
    hc = 0;
    repeat (p + 1) @(posedge CLK_SYS_I);
    repeat (2 * (p + 1)) begin
      @(negedge CLK_SYS_I);
      ho += int'(OPEN_PWM_O === 1'b1);
      hc += int'(CLOSE_PWM_O === 1'b1);
    end
    chk("open_high", (m == 2'b01) ? exp_high(d, p) : 0, ho);
    chk("close_high", (m == 2'b10) ? exp_high(d, p) : 0, hc);
    $display("Test pwm p=%0d d=%0d mode=%0d done", p, d, m);
  endtask

  task automatic wait_irq(input int lim, input bit e);
    dpwm_host_inst.finish_upd(lim, got);
    chk("irq", e, got);
    if (e && !got) results();
  endtask

  initial begin
    repeat (12) @(posedge CLK_SYS_I);
    RST_I <= 1'b0;
    rchk(32'h00, "period", 32'hffffffff, 32'h00000fa0);
    rchk(32'h04, "duty", 32'hffffffff, 32'h000007d0);
    dpwm_host_inst.wr(32'h1c, 32'h0000abcd);
    rchk(32'h1c, "unmapped", 32'hffffffff, 32'h0);
    $display("Test reset done");
    for (int i = 0; i < 6; i++) begin
      p = rnd(10, 16);
      d = (i == 0) ? 0 : (i == 1) ? p : (i == 2) ? p + 2 : rnd(1, p);
      dpwm_host_inst.wr(dpwm_pkg::ADDR_PERIOD, p);
      dpwm_host_inst.wr(dpwm_pkg::ADDR_DUTY, d);
      set_mode(2'((i % 3) + 1));
      measure(2'((i % 3) + 1));
    end
    set_mode(2'b11);
    p = rnd(10, 16);
    d = rnd(1, p);
    dpwm_host_inst.update(p, d);
    wait_irq(60, 1'b0);
    set_mode(2'b01);
    wait_irq(40, 1'b1);
    measure(2'b01);
    set_mode(2'b10);
    for (int i = 0; i < 2; i++) begin
      p = rnd(10, 16);
      d = rnd(1, p);
      dpwm_host_inst.update(p, d);
      wait_irq(40, 1'b1);
      measure(2'b10);
    end
    for (int i = 0; i < 5; i++)
      dpwm_host_inst.wr(dpwm_pkg::ADDR_FIFO, (i % 2) ? d : p);
    rchk(dpwm_pkg::ADDR_STAT, "level", 32'h70, 32'h40);
    for (int i = 1; i >= 0; i--) begin
      dpwm_host_inst.wr(dpwm_pkg::ADDR_FLAG, 32'h4);
      wait_irq(40, 1'b1);
      rchk(dpwm_pkg::ADDR_STAT, "level", 32'h70, i * 32);
    end
    $display("Test fifo done");
    // Flag raised with an empty exchange buffer: both pops run dry
    dpwm_host_inst.wr(dpwm_pkg::ADDR_FLAG, 32'h4);
    wait_irq(40, 1'b1);
    rchk(dpwm_pkg::ADDR_STAT, "underflow", 32'h1, 32'h1);
    dpwm_host_inst.wr(dpwm_pkg::ADDR_STAT, 32'h1);
    rchk(dpwm_pkg::ADDR_STAT, "underflow", 32'h1, 32'h0);
    set_mode(2'b11);
    rchk(dpwm_pkg::ADDR_COUNT, "count", 32'hffffffff, p);
    $display("Test underflow done");
    results();
  end
endmodule
